/* File: inc/fpe_pkg.sv */
// Constants shared by the flash program and erase sequencer
package fpe_pkg;
  // Link protocol selection
  localparam logic [2:0] PROTO_1S1S1S = 3'h0;
  localparam logic [2:0] PROTO_1S1S8S = 3'h1;
  localparam logic [2:0] PROTO_1S8S8S = 3'h2;
  localparam logic [2:0] PROTO_8S8S8S = 3'h3;
  localparam logic [2:0] PROTO_8D8D8D = 3'h4;
  // Command opcodes, values arbitrary
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_CLEAR_FAIL   = 8'h82;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h12;
  localparam logic [7:0] OP_OTP_PROGRAM  = 8'h42;
  localparam logic [7:0] OP_LOCK_PROGRAM = 8'he3;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hdc;
  // Bit positions in status_one_volatile
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_EERR = 5;
  localparam int ST_PERR = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Page bit in config_three_volatile
  localparam int CFG3_PAGE_BIT = 4;
  localparam int BUF_DEPTH = 512;
  localparam int BUF_AW    = 9;
  localparam logic [8:0] PAGE_MASK_256 = 9'h0ff;
  localparam logic [8:0] PAGE_MASK_512 = 9'h1ff;
  // Sector and one-time-programmable region layout
  localparam int N_SECT      = 128;
  localparam int SECT_LSB    = 18;
  localparam int SECT_W      = 7;
  localparam int OTP_REGIONS = 32;
  localparam int OTP_REG_LSB = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Link sync reset value: chip select idle high
  localparam logic [9:0] LINK_RESET = 10'h200;
  // Self-timed operation length
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_TIME_NS    = 2000;
  localparam int OP_CYC        = OP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] OP_CNT_LAST = 8'(OP_CYC - 1);
endpackage

/* File: rtl/sync2.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST;
      q_o    <= RST;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

/* File: rtl/page_buffer.sv */
// Page buffer memory with registered read data
`timescale 1ns/1ps
module page_buffer (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [8:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [8:0] raddr_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [fpe_pkg::BUF_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

/* File: rtl/flash_program_erase_control.sv */
// Program and erase sequencer of a serial NOR flash command port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Program in single, octal-input and octal modes; erase not octal-input.
// - One-byte command on one line; two-byte command on octal, DDR both edges.
// - Program or erase runs only while the write enable latch is set.
// - Completion of program or erase clears the write enable latch.
// - Busy flag high during the self-timed operation, low on successful completion, kept high on failure.
// - Program failure reported in status bit 6.
// - Erase failure reported in status bit 5.
// - Program to a protected sector is skipped and flags program error.
// - Erase of a protected sector is skipped and flags erase error.
// - Operation starts only when chip select returns high.
// - Repeat programming of a unit without erase turns its ECC off.
// - With two-bit ECC, second program pass in a sector flags error.
// - Page of 256 or 512 bytes from config bit 4 (always 512 for OTP program), page aligned.
// - Loading wraps to byte zero of the page and overwrites.
// - Only received bytes are programmed; the rest stay unchanged.
// - Zeros into a locked region fail with program error.
// - Lock bit program protects a sector; aborts when lock bits guarded.
// - Erase sets all bits to one.
// - Busy flag sits at status bit 0.
// - Clear fail flags resets bits 5 and 6, works busy, keeps latch.
module flash_program_erase_control (
  input  wire logic         MCLK_I,
  input  wire logic         RST_I,
  input  wire logic         SCK_I,
  input  wire logic         CS_N_I,
  input  wire logic [7:0]   DQ_I,
  input  wire logic [2:0]   PROTO_I,
  input  wire logic [7:0]   CFG3_I,
  input  wire logic [127:0] BLOCK_PROT_I,
  input  wire logic [31:0]  OTP_LOCK_I,
  input  wire logic         LOCK_MODE_I,
  input  wire logic         PERM_LOCK_I,
  input  wire logic         LOCK_FREEZE_I,
  input  wire logic         ECC2_EN_I,
  input  wire logic         ARR_FAIL_I,
  output logic      [7:0]   STATUS_O,
  output logic              ARR_WR_O,
  output logic              ARR_OTP_O,
  output logic      [31:0]  ARR_ADDR_O,
  output logic      [7:0]   ARR_DATA_O,
  output logic              ARR_ERASE_O,
  output logic              ARR_ECC_OFF_O,
  output logic      [127:0] LOCK_BITS_O
);
  typedef enum logic [3:0] {
    P_CMD = 4'h1, P_ADDR = 4'h2, P_DATA = 4'h4, P_SKIP = 4'h8
  } phase_t;
  typedef enum logic [3:0] {
    E_IDLE = 4'h1, E_WALK = 4'h2, E_WAIT = 4'h4, E_DONE = 4'h8
  } eng_t;

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = op == fpe_pkg::OP_PAGE_PROGRAM || op == fpe_pkg::OP_OTP_PROGRAM
            || op == fpe_pkg::OP_LOCK_PROGRAM || op == fpe_pkg::OP_SECTOR_ERASE;
  endfunction

  function automatic logic has_data(input logic [7:0] op);
    has_data = op == fpe_pkg::OP_PAGE_PROGRAM || op == fpe_pkg::OP_OTP_PROGRAM;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Link sampling
  logic [9:0]   lk_s;
  logic [1:0]   lk_p_q;
  phase_t       ph_q, ph_d;
  logic [2:0]   bit_q, bit_d;
  logic [1:0]   nb_q, nb_d;
  logic [7:0]   sh_q, op_q, op_d;
  logic [31:0]  adr_q, adr_d;
  logic [8:0]   ld_q, ld_d;
  logic         done_q, done_d, bad_q, bad_d;
  logic [511:0] vld_q;
  logic [7:0]   status_one_volatile_q, st_d;
  eng_t         eng_q, eng_d;
  logic [8:0]   k_q, k_d, so_q, pm_q, ra_p_q;
  logic [7:0]   w_q, w_d, rdata;
  logic         otp_q, er_q, pend_q, fail_q, wv_q;
  logic [127:0] seen_q, lock_q;

  sync2 #(
    .W   (10),
    .RST (fpe_pkg::LINK_RESET)
  ) u_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   ({CS_N_I, SCK_I, DQ_I}),
    .q_o   (lk_s)
  );

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      lk_p_q <= 2'h2;
    end else begin
      lk_p_q <= lk_s[9:8];
    end
  end

  wire       cs_n_s   = lk_s[9];
  wire       sck_s    = lk_s[8];
  wire [7:0] dq_s     = lk_s[7:0];
  wire       cs_rise  = cs_n_s & ~lk_p_q[1];
  wire       cs_fall  = ~cs_n_s & lk_p_q[1];
  wire       sck_rise = sck_s & ~lk_p_q[0];
  wire       sck_fall = ~sck_s & lk_p_q[0];
  wire       ddr      = PROTO_I == fpe_pkg::PROTO_8D8D8D;
  wire       oct_cmd  = ddr || PROTO_I == fpe_pkg::PROTO_8S8S8S;
  wire       oct_adr  = oct_cmd || PROTO_I == fpe_pkg::PROTO_1S8S8S;
  wire       oct_dat  = PROTO_I != fpe_pkg::PROTO_1S1S1S;
  // DDR moves data on both edges of the link clock
  wire       edge_ok  = ~cs_n_s & ~lk_p_q[1]
                      & (sck_rise | (ddr & sck_fall));
  wire       lane8    = (ph_q == P_CMD) ? oct_cmd :
                        (ph_q == P_ADDR) ? oct_adr : oct_dat;
  wire [7:0] sh_n     = {sh_q[6:0], dq_s[0]};
  wire [7:0] byte_v   = lane8 ? dq_s : sh_n;
  wire       byte_ok  = edge_ok & (lane8 | bit_q == 3'h7);
  // Octal commands carry a second byte that is not decoded
  wire       cmd_last = ~oct_cmd | nb_q == 2'h1;
  wire [7:0] op_now   = (nb_q == 2'h0) ? byte_v : op_q;
  wire       busy     = status_one_volatile_q[fpe_pkg::ST_BUSY];
  wire       wel      = status_one_volatile_q[fpe_pkg::ST_WEL];
  wire       is_otp   = op_q == fpe_pkg::OP_OTP_PROGRAM;
  wire [8:0] pmask    = (is_otp | CFG3_I[fpe_pkg::CFG3_PAGE_BIT]) ?
                        fpe_pkg::PAGE_MASK_512 :
                        fpe_pkg::PAGE_MASK_256;
  wire [9:0] otp_a    = {adr_q[9], ld_q};
  wire [4:0] otp_reg  = otp_a[9:fpe_pkg::OTP_REG_LSB];
  wire       buf_we   = byte_ok & ph_q == P_DATA & ~busy;

  //////////////////////////////////////////////////////////////////////////
  // Command, address and data parsing
  always_comb begin
    ph_d   = ph_q;
    bit_d  = bit_q;
    nb_d   = nb_q;
    op_d   = op_q;
    adr_d  = adr_q;
    ld_d   = ld_q;
    done_d = done_q;
    bad_d  = bad_q;
    if (cs_fall) begin
      ph_d   = P_CMD;
      bit_d  = 3'h0;
      nb_d   = 2'h0;
      done_d = 1'b0;
      bad_d  = 1'b0;
    end else if (edge_ok) begin
      bit_d = lane8 ? 3'h0 : 3'(bit_q + 3'h1);
      if (byte_ok) begin
        nb_d = 2'(nb_q + 2'h1);
        unique case (ph_q)
          P_CMD: begin
            if (nb_q == 2'h0) begin
              op_d = byte_v;
            end
            if (cmd_last) begin
              nb_d   = 2'h0;
              ph_d   = has_addr(op_now) ? P_ADDR : P_SKIP;
              done_d = ~has_addr(op_now);
            end
          end
          P_ADDR: begin
            if (~busy) begin
              adr_d = {adr_q[23:0], byte_v};
            end
            if (nb_q == 2'h3) begin
              ph_d   = has_data(op_q) ? P_DATA : P_SKIP;
              done_d = ~has_data(op_q);
              ld_d   = {adr_q[0], byte_v} & pmask;
            end
          end
          P_DATA: begin
            // Load pointer wraps inside the page
            ld_d   = 9'(ld_q + 9'h1) & pmask;
            done_d = 1'b1;
            if (is_otp && OTP_LOCK_I[otp_reg]
                && byte_v != fpe_pkg::ERASED_BYTE) begin
              bad_d = 1'b1;
            end
          end
          P_SKIP: begin
            nb_d = nb_q;
          end
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ph_q   <= P_SKIP;
      bit_q  <= 3'h0;
      nb_q   <= 2'h0;
      sh_q   <= 8'h00;
      op_q   <= 8'h00;
      adr_q  <= 32'h0;
      ld_q   <= 9'h000;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      bit_q  <= bit_d;
      nb_q   <= nb_d;
      sh_q   <= edge_ok ? sh_n : sh_q;
      op_q   <= op_d;
      adr_q  <= adr_d;
      ld_q   <= ld_d;
      done_q <= done_d;
      bad_q  <= bad_d;
    end
  end

  // Byte valid mask: bytes never sent are never programmed
  always_ff @(posedge MCLK_I) begin
    if (RST_I || (cs_fall && !busy)) begin
      vld_q <= '0;
    end else if (buf_we) begin
      vld_q[ld_q] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Execution decode at chip select release
  wire       go       = cs_rise & done_q;
  wire       x_arm    = go & ~busy & wel;
  wire       er_ok    = ~(PROTO_I == fpe_pkg::PROTO_1S1S8S
                        || PROTO_I == fpe_pkg::PROTO_1S8S8S);
  wire       x_wren   = go & ~busy & op_q == fpe_pkg::OP_WRITE_ENABLE;
  wire       x_clr    = go & op_q == fpe_pkg::OP_CLEAR_FAIL;
  wire       x_pp     = x_arm & op_q == fpe_pkg::OP_PAGE_PROGRAM;
  wire       x_otp    = x_arm & is_otp;
  wire       x_lock   = x_arm & op_q == fpe_pkg::OP_LOCK_PROGRAM;
  wire       x_er     = x_arm & er_ok & op_q == fpe_pkg::OP_SECTOR_ERASE;
  wire [6:0] sec      = adr_q[fpe_pkg::SECT_LSB +: fpe_pkg::SECT_W];
  wire       prot     = BLOCK_PROT_I[sec] | lock_q[sec];
  wire       lk_abort = ~LOCK_MODE_I | ~PERM_LOCK_I | ~LOCK_FREEZE_I;
  wire       p_rej    = (x_pp & prot) | (x_otp & bad_q)
                      | (x_lock & lk_abort);
  wire       e_rej    = x_er & prot;
  wire       walk_go  = (x_pp & ~prot) | (x_otp & ~bad_q);
  wire       er_go    = x_er & ~prot;
  wire       lock_go  = x_lock & ~lk_abort;
  wire       ecc2_hit = x_pp & ECC2_EN_I & seen_q[sec];
  wire       eng_done = eng_q == E_DONE;
  wire       done_err = fail_q | pend_q;
  wire [8:0] ra       = 9'(so_q + k_q) & pm_q;
  wire [31:0] wr_adr  = otp_q ? {22'h0, adr_q[9], ra_p_q} :
                        {adr_q[31:9], (adr_q[8:0] & ~pm_q) | ra_p_q};

  page_buffer u_buf (
    .clk_i   (MCLK_I),
    .we_i    (buf_we),
    .waddr_i (ld_q),
    .wdata_i (byte_v),
    .raddr_i (ra),
    .rdata_o (rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Self-timed engine
  always_comb begin
    eng_d = eng_q;
    k_d   = k_q;
    w_d   = w_q;
    unique case (eng_q)
      E_IDLE: begin
        k_d = 9'h000;
        w_d = 8'h00;
        if (walk_go) begin
          eng_d = E_WALK;
        end else if (er_go || lock_go) begin
          eng_d = E_WAIT;
        end
      end
      E_WALK: begin
        k_d = 9'(k_q + 9'h1);
        if (k_q == pm_q) begin
          eng_d = E_WAIT;
        end
      end
      E_WAIT: begin
        w_d = 8'(w_q + 8'h1);
        if (w_q == fpe_pkg::OP_CNT_LAST) begin
          eng_d = E_DONE;
        end
      end
      E_DONE: begin
        eng_d = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      eng_q <= E_IDLE;
      k_q   <= 9'h000;
      w_q   <= 8'h00;
    end else begin
      eng_q <= eng_d;
      k_q   <= k_d;
      w_q   <= w_d;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      so_q   <= 9'h000;
      pm_q   <= 9'h000;
      otp_q  <= 1'b0;
      er_q   <= 1'b0;
      pend_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (eng_q == E_IDLE) begin
      so_q   <= adr_q[8:0] & pmask;
      pm_q   <= pmask;
      otp_q  <= x_otp;
      er_q   <= er_go;
      pend_q <= ecc2_hit;
      fail_q <= 1'b0;
    end else begin
      fail_q <= fail_q | ARR_FAIL_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Array side and lock bits
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ra_p_q        <= 9'h000;
      wv_q          <= 1'b0;
      ARR_WR_O      <= 1'b0;
      ARR_OTP_O     <= 1'b0;
      ARR_ADDR_O    <= 32'h0;
      ARR_DATA_O    <= 8'h00;
      ARR_ERASE_O   <= 1'b0;
      ARR_ECC_OFF_O <= 1'b0;
    end else begin
      ra_p_q      <= ra;
      wv_q        <= eng_q == E_WALK;
      ARR_WR_O    <= wv_q & vld_q[ra_p_q];
      ARR_OTP_O   <= otp_q;
      ARR_DATA_O  <= rdata;
      // Array sets every bit of the sector to one
      ARR_ERASE_O <= er_go;
      ARR_ADDR_O  <= er_go ? adr_q : (wv_q ? wr_adr : ARR_ADDR_O);
      if (eng_q == E_IDLE) begin
        ARR_ECC_OFF_O <= x_pp & seen_q[sec];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      seen_q <= '0;
      lock_q <= '0;
    end else begin
      if (x_pp && walk_go) begin
        seen_q[sec] <= 1'b1;
      end
      if (er_go) begin
        seen_q[sec] <= 1'b0;
      end
      if (lock_go) begin
        lock_q[sec] <= 1'b1;
      end
    end
  end

  assign LOCK_BITS_O = lock_q;

  //////////////////////////////////////////////////////////////////////////
  // Status flags; a setting event wins over a clear in the same cycle
  always_comb begin
    st_d = status_one_volatile_q;
    if (x_wren) begin
      st_d[fpe_pkg::ST_WEL] = 1'b1;
    end
    if (x_clr) begin
      st_d[fpe_pkg::ST_PERR] = 1'b0;
      st_d[fpe_pkg::ST_EERR] = 1'b0;
      if (eng_q == E_IDLE) begin
        st_d[fpe_pkg::ST_BUSY] = 1'b0;
      end
    end
    if (walk_go || er_go || lock_go) begin
      st_d[fpe_pkg::ST_BUSY] = 1'b1;
    end
    if (p_rej || e_rej) begin
      st_d[fpe_pkg::ST_PERR] = st_d[fpe_pkg::ST_PERR] | p_rej;
      st_d[fpe_pkg::ST_EERR] = st_d[fpe_pkg::ST_EERR] | e_rej;
      st_d[fpe_pkg::ST_BUSY] = 1'b1;
      st_d[fpe_pkg::ST_WEL]  = 1'b0;
    end
    if (eng_done) begin
      st_d[fpe_pkg::ST_WEL]  = 1'b0;
      st_d[fpe_pkg::ST_BUSY] = done_err;
      if (er_q) begin
        st_d[fpe_pkg::ST_EERR] = st_d[fpe_pkg::ST_EERR] | done_err;
      end else begin
        st_d[fpe_pkg::ST_PERR] = st_d[fpe_pkg::ST_PERR] | done_err;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      status_one_volatile_q <= fpe_pkg::STATUS_RESET;
    end else begin
      status_one_volatile_q <= st_d;
    end
  end

  assign STATUS_O = status_one_volatile_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  a_walk_needs_wel: assert property (
    $rose(eng_q == E_WALK) |-> $past(wel))
    else $error("program started without write enable");
  a_done_clears_wel: assert property (
    eng_done |=> !wel)
    else $error("write enable kept after completion");
  a_busy_running: assert property (
    eng_q != E_IDLE |-> STATUS_O[0])
    else $error("busy low during operation");
  a_busy_release: assert property (
    eng_done && !done_err |=> !STATUS_O[0] [*2])
    else $error("busy not released on success");
  a_prog_fail: assert property (
    eng_done && !er_q && done_err |=> STATUS_O[6] && STATUS_O[0])
    else $error("program failure not flagged");
  a_erase_fail: assert property (
    eng_done && er_q && done_err |=> STATUS_O[5] && !STATUS_O[6])
    else $error("erase failure not flagged");
  a_prot_program: assert property (
    x_pp && prot |=> STATUS_O[6] && eng_q == E_IDLE ##1 !ARR_WR_O)
    else $error("protected program not rejected");
  a_prot_erase: assert property (
    x_er && prot |=> STATUS_O[5] ##1 !ARR_ERASE_O)
    else $error("protected erase not rejected");
  a_start_on_cs: assert property (
    $rose(STATUS_O[0]) |-> $past(cs_rise))
    else $error("operation started without chip select release");
  a_octin_erase: assert property (
    go && op_q == fpe_pkg::OP_SECTOR_ERASE && !er_ok |-> ##2 !ARR_ERASE_O)
    else $error("erase taken in octal input mode");
  a_ecc2_error: assert property (
    ecc2_hit && !prot |-> ##[100:700] STATUS_O[6])
    else $error("second pass not flagged");
  a_load_wrap: assert property (
    ph_q == P_DATA |-> (ld_q & ~pmask) == 9'h000)
    else $error("load pointer left the page");
  a_unsent_kept: assert property (
    wv_q && !vld_q[ra_p_q] |=> !ARR_WR_O)
    else $error("unsent byte programmed");
  a_otp_locked: assert property (
    x_otp && bad_q |=> STATUS_O[6] && eng_q == E_IDLE)
    else $error("locked region program not rejected");
  a_lock_abort: assert property (
    x_lock && lk_abort |=> $stable(lock_q) && STATUS_O[6])
    else $error("guarded lock bit changed");
  a_clear_flags: assert property (
    x_clr && !eng_done |=> !STATUS_O[6] && !STATUS_O[5]
    && STATUS_O[1] == $past(wel))
    else $error("fail flags not cleared");

  c_prog_done:  cover property (eng_done && !er_q && !done_err);
  c_erase_done: cover property (eng_done && er_q);
  c_wrap_load:  cover property (buf_we && ld_q == pmask);
  c_clr_busy:   cover property (x_clr && STATUS_O[0]);
endmodule

/* File: tb/host_link.sv */
// Host controller model that frames commands on the serial link
`timescale 1ns/1ps
module host_link (
  input  wire logic       clk_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [7:0] dq_o
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    dq_o   = 8'h00;
  end

  // Data moves two cycles clear of every clock edge
  task automatic beat(input logic [7:0] d, input bit ddr);
    repeat (2) @(posedge clk_i);
    dq_o <= d;
    repeat (2) @(posedge clk_i);
    if (ddr) begin
      sck_o <= ~sck_o;
    end else begin
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask

  task automatic put(input logic [7:0] b, input bit oct, input bit ddr);
    if (oct) begin
      beat(b, ddr);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        beat({7'h00, b[i]}, 1'b0);
      end
    end
  endtask

  // Command, optional 4-byte address, n data bytes
  task automatic send(input logic [2:0] p, input logic [7:0] op,
                      input bit ha, input logic [31:0] a,
                      input int n, input logic [7:0] d);
    bit ddr;
    ddr = (p == fpe_pkg::PROTO_8D8D8D);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    put(op, p >= fpe_pkg::PROTO_8S8S8S, ddr);
    if (p >= fpe_pkg::PROTO_8S8S8S) begin
      put(~op, 1'b1, ddr);
    end
    for (int i = 3; ha && i >= 0; i--) begin
      put(a[8*i+:8], p >= fpe_pkg::PROTO_1S8S8S, ddr);
    end
    for (int i = 0; i < n; i++) begin
      put(8'(d + i + i / 256), p >= fpe_pkg::PROTO_1S1S8S, ddr);
    end
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b1;
    dq_o   <= ~dq_o;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] ER = fpe_pkg::OP_SECTOR_ERASE;
  localparam logic [7:0] PG = fpe_pkg::OP_PAGE_PROGRAM;
  localparam logic [7:0] LK = fpe_pkg::OP_LOCK_PROGRAM;
  typedef struct packed {
    logic [2:0] p;
    logic [7:0] op;
    logic [7:0] st;
    int         wr;
    int         er;
  } row_t;
  row_t rows[10] = '{'{3'h0, ER, 8'h00, 0, 1}, '{3'h1, ER, 8'h02, 0, 0},
    '{3'h2, ER, 8'h02, 0, 0}, '{3'h3, ER, 8'h00, 0, 1},
    '{3'h4, ER, 8'h00, 0, 1}, '{3'h0, PG, 8'h00, 2, 0},
    '{3'h1, PG, 8'h00, 2, 0}, '{3'h2, PG, 8'h00, 2, 0},
    '{3'h3, PG, 8'h00, 2, 0}, '{3'h4, PG, 8'h00, 2, 0}};
  logic         MCLK_I        = 1'b0;
  logic         RST_I         = 1'b1;
  logic         SCK_I;
  logic         CS_N_I;
  logic [7:0]   DQ_I;
  logic [2:0]   PROTO_I       = 3'h0;
  logic [7:0]   CFG3_I        = 8'h00;
  logic [127:0] BLOCK_PROT_I  = '0;
  logic [31:0]  OTP_LOCK_I    = 32'h0000_0000;
  logic         ARR_OTP_O;
  logic         LOCK_MODE_I   = 1'b1;
  logic         PERM_LOCK_I   = 1'b1;
  logic         LOCK_FREEZE_I = 1'b1;
  logic         ECC2_EN_I     = 1'b0;
  logic         ARR_FAIL_I    = 1'b0;
  logic [7:0]   STATUS_O;
  logic         ARR_WR_O;
  logic [31:0]  ARR_ADDR_O;
  logic [7:0]   ARR_DATA_O;
  logic         ARR_ERASE_O;
  logic         ARR_ECC_OFF_O;
  logic [127:0] LOCK_BITS_O;
  int           fail_count    = 0;
  int           compares      = 0;
  int           ner;
  int           nbusy;
  int           necc;
  int           notp;
  logic [39:0]  wq[$];

  always #10 MCLK_I = ~MCLK_I;

  host_link host_link_i (.clk_i(MCLK_I), .sck_o(SCK_I), .cs_n_o(CS_N_I),
    .dq_o(DQ_I));

  flash_program_erase_control flash_program_erase_control_i (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
    .DQ_I(DQ_I), .PROTO_I(PROTO_I), .CFG3_I(CFG3_I),
    .BLOCK_PROT_I(BLOCK_PROT_I), .OTP_LOCK_I(OTP_LOCK_I),
    .LOCK_MODE_I(LOCK_MODE_I), .PERM_LOCK_I(PERM_LOCK_I),
    .LOCK_FREEZE_I(LOCK_FREEZE_I), .ECC2_EN_I(ECC2_EN_I),
    .ARR_FAIL_I(ARR_FAIL_I), .STATUS_O(STATUS_O), .ARR_WR_O(ARR_WR_O),
    .ARR_OTP_O(ARR_OTP_O), .ARR_ADDR_O(ARR_ADDR_O),
    .ARR_DATA_O(ARR_DATA_O),
    .ARR_ERASE_O(ARR_ERASE_O), .ARR_ECC_OFF_O(ARR_ECC_OFF_O),
    .LOCK_BITS_O(LOCK_BITS_O));

  always @(posedge MCLK_I) begin
    if (ARR_WR_O === 1'b1) wq.push_back({ARR_ADDR_O, ARR_DATA_O});
    if (ARR_ERASE_O === 1'b1) ner++;
    if (STATUS_O[0] === 1'b1) nbusy++;
    if (ARR_ECC_OFF_O === 1'b1) necc++;
    if (ARR_WR_O === 1'b1 && ARR_OTP_O === 1'b1) notp++;
  end

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    host_link_i.send(PROTO_I, op, 1'b0, 32'h0, 0, 8'h00);
    repeat (8) @(posedge MCLK_I);
  endtask

  // Sends one operation and waits until it ends or reports an error
  task automatic run(input logic [2:0] p, input logic [7:0] op,
                     input logic [31:0] a, input int n);
    PROTO_I <= p;
    wq.delete();
    ner   = 0;
    nbusy = 0;
    necc  = 0;
    notp  = 0;
    host_link_i.send(p, op, 1'b1, a, n, 8'ha0);
    repeat (8) @(posedge MCLK_I);
    // Waits while busy is set; an error flag ends the wait at once
    for (int i = 0; i < 3000 && STATUS_O[0] === 1'b1
         && STATUS_O[6:5] === 2'b00; i++) @(posedge MCLK_I);
    repeat (2) @(posedge MCLK_I);
  endtask

  initial begin
    #1_800_000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge MCLK_I);
    RST_I <= 1'b0;
    repeat (4) @(posedge MCLK_I);
    chk(STATUS_O, 8'h00);
    foreach (rows[k]) begin
      PROTO_I <= rows[k].p;
      @(posedge MCLK_I);
      cmd(fpe_pkg::OP_WRITE_ENABLE);
      chk(STATUS_O, 8'h02);
      run(rows[k].p, rows[k].op, 32'h100, 2);
      chk(STATUS_O, rows[k].st);
      chk(wq.size(), rows[k].wr);
      chk(ner, rows[k].er);
      chk(nbusy >= 100, rows[k].wr + rows[k].er > 0);
    end
    run(3'h3, PG, 32'h100, 2);
    chk(wq.size(), 0);
    for (int c = 0; c < 2; c++) begin
      CFG3_I <= c ? 8'h10 : 8'h00;
      cmd(fpe_pkg::OP_WRITE_ENABLE);
      run(3'h3, PG, 32'h1fe, 3);
      chk(wq[0], {32'h1fe, 8'ha0});
      chk(wq[2], {c ? 32'h0 : 32'h100, 8'ha2});
    end
    CFG3_I <= 8'h00;
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, PG, 32'h100, 257);
    chk(wq.size(), 256);
    chk(wq[0], {32'h100, 8'ha1});
    BLOCK_PROT_I[2] <= 1'b1;
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, PG, 32'h80000, 2);
    chk(STATUS_O, 8'h41);
    chk(wq.size(), 0);
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    chk(STATUS_O, 8'h00);
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, LK, 32'h40000, 0);
    chk(LOCK_BITS_O[1], 1'b1);
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, ER, 32'h40000, 0);
    chk({STATUS_O, 8'(ner)}, 16'h2100);
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    for (int g = 0; g < 3; g++) begin
      {LOCK_MODE_I, PERM_LOCK_I, LOCK_FREEZE_I} <= ~(3'h1 << g);
      cmd(fpe_pkg::OP_WRITE_ENABLE);
      run(3'h3, LK, 32'hc0000, 0);
      chk({STATUS_O, 7'h00, LOCK_BITS_O[3]}, 16'h4100);
      cmd(fpe_pkg::OP_CLEAR_FAIL);
    end
    OTP_LOCK_I <= 32'h0000_0001;
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, fpe_pkg::OP_OTP_PROGRAM, 32'h0, 4);
    chk({STATUS_O, 8'(wq.size())}, 16'h4100);
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, fpe_pkg::OP_OTP_PROGRAM, 32'h20, 16);
    chk(STATUS_O, 8'h00);
    chk(notp, 16);
    chk(wq[0], {32'h20, 8'ha0});
    chk(wq[15], {32'h2f, 8'haf});
    ECC2_EN_I <= 1'b1;
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, PG, 32'h100, 2);
    chk(STATUS_O, 8'h41);
    chk(necc > 0, 1'b1);
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    ARR_FAIL_I <= 1'b1;
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    run(3'h3, ER, 32'h100, 0);
    chk(STATUS_O, 8'h21);
    ARR_FAIL_I <= 1'b0;
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    cmd(fpe_pkg::OP_WRITE_ENABLE);
    cmd(fpe_pkg::OP_CLEAR_FAIL);
    chk(STATUS_O, 8'h02);
    close_out();
  end
endmodule
